// *** hdl/idf_pkg.sv ***
// Constants, types and shared helpers for the instruction decode and data format block.
package idf_pkg;
  // ----------------------------------------
  // Core register numbers
  // ----------------------------------------
  localparam int REG_W = 6;
  localparam logic [5:0] EXT_REG_LO = 6'h20;
  localparam logic [5:0] EXT_REG_HI = 6'h3B;
  localparam logic [5:0] LIMM_REG = 6'h3E;
  // ----------------------------------------
  // Instruction fields
  // ----------------------------------------
  localparam int GRP_MSB = 31;
  localparam int GRP_LSB = 27;
  localparam logic [4:0] GRP_LAST32 = 5'h07;
  localparam logic [4:0] GRP_EXT32_USER = 5'h05;
  localparam logic [4:0] GRP_EXT32_RSV = 5'h06;
  localparam logic [4:0] GRP_EXT16_A = 5'h09;
  localparam logic [4:0] GRP_EXT16_B = 5'h0A;
  localparam int B_LO_MSB = 26;
  localparam int B_LO_LSB = 24;
  localparam int B_HI_MSB = 14;
  localparam int B_HI_LSB = 12;
  localparam int C_MSB = 11;
  localparam int C_LSB = 6;
  localparam int A_MSB = 5;
  localparam int A_LSB = 0;
  localparam int S16_C_MSB = 23;
  localparam int S16_C_LSB = 21;
  localparam int CC_MSB = 4;
  localparam int CC_LSB = 0;
  // ----------------------------------------
  // Data sizes, widen operations and auxiliary space
  // ----------------------------------------
  localparam logic [1:0] SZ_LONG = 2'h0;
  localparam logic [1:0] SZ_BYTE = 2'h1;
  localparam logic [1:0] SZ_HALF = 2'h2;
  localparam logic [1:0] WOP_ZB = 2'h0;
  localparam logic [1:0] WOP_SB = 2'h1;
  localparam logic [1:0] WOP_ZH = 2'h2;
  localparam logic [1:0] WOP_SH = 2'h3;
  localparam logic [31:0] BCR_LO_A = 32'h0000_0060;
  localparam logic [31:0] BCR_HI_A = 32'h0000_007F;
  localparam logic [31:0] BCR_LO_B = 32'h0000_00C0;
  localparam logic [31:0] BCR_HI_B = 32'h0000_00FF;
  // ----------------------------------------
  // Register map and bus
  // ----------------------------------------
  localparam logic [7:0] OFS_DBG = 8'h00;
  localparam logic [7:0] OFS_STAT = 8'h04;
  localparam logic [7:0] OFS_CFG = 8'h08;
  localparam logic [7:0] OFS_DEC = 8'h0C;
  localparam int DBG_START = 0;
  localparam int DBG_STOP = 1;
  localparam int DBG_STEP = 2;
  localparam int CFG_BE = 0;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  typedef enum logic [1:0] {RUN = 2'b00, HALT = 2'b01, STEP = 2'b10, SLEEP = 2'b11} idf_run_t;

  function automatic logic [31:0] idf_widen(input logic [31:0] v, input logic half, input logic sgn);
    return half ? {{16{sgn & v[15]}}, v[15:0]} : {{24{sgn & v[7]}}, v[7:0]};
  endfunction : idf_widen
endpackage : idf_pkg

// *** hdl/idf_cond.sv ***
// Condition code evaluation for base codes, with forwarding of extension codes.
module idf_cond import idf_pkg::*; (
  // Code and flags
  input logic [4:0] code,
  input logic z,
  input logic n,
  input logic c,
  input logic v,
  input logic ext_true,
  // Result
  output logic pass,
  output logic is_ext
);
  logic base;

  always_comb begin
    unique case (code[3:0])
      4'h0: base = 1'b1;
      4'h1: base = z;
      4'h2: base = !z;
      4'h3: base = n;
      4'h4: base = !n;
      4'h5: base = c;
      4'h6: base = !c;
      4'h7: base = v;
      4'h8: base = !v;
      4'h9: base = (n == v) && !z;
      4'hA: base = n == v;
      4'hB: base = n != v;
      4'hC: base = z || (n != v);
      4'hD: base = !c && !z;
      4'hE: base = c || z;
      4'hF: base = !n && !z;
    endcase
  end

  assign is_ext = code[4];
  assign pass = is_ext ? ext_true : base;
endmodule : idf_cond

// *** hdl/idf_ldfmt.sv ***
// Load data lane selection, widening and alignment check.
module idf_ldfmt import idf_pkg::*; (
  // Access
  input logic [1:0] addr,
  input logic [1:0] size,
  input logic sgn,
  input logic big,
  input logic [31:0] rdata,
  // Result
  output logic [31:0] data,
  output logic misaligned
);
  wire [1:0] lane = big ? ~addr : addr;
  wire [7:0] byte_v = rdata[8*lane +: 8];
  wire hi_half = big ? !addr[1] : addr[1];
  wire [15:0] half_v = hi_half ? rdata[31:16] : rdata[15:0];

  // Byte lane equals the byte address in little-endian order and its inverse in big-endian order.
  assign data = (size == SZ_BYTE) ? idf_widen({24'h0, byte_v}, 1'b0, sgn) :
                (size == SZ_HALF) ? idf_widen({16'h0, half_v}, 1'b1, sgn) : rdata;
  assign misaligned = (size == SZ_LONG) ? (addr != 2'h0) : (size == SZ_HALF) ? addr[0] : 1'b0;
endmodule : idf_ldfmt

// *** hdl/idf_core.sv ***
// Instruction decode, run control and data formatting block with an AHB-Lite register slave.
// Summary of operation
// - Register numbers are six bits wide, giving 64 core register positions.
// - Register numbers 32 to 59 are flagged for the extension logic.
// - Auxiliary accesses carry a 32-bit address and always move a whole word.
// - Auxiliary 0x60-0x7F and 0xC0-0xFF are read-only build configuration registers.
// - Five-bit group field: groups 0 to 7 are 32-bit, others 16-bit.
// - Two extension groups per length; user extensions use one 32-bit, two 16-bit.
// - Extension instructions write back a result taken from an external ALU.
// - Condition codes 0x00-0x0F use only the Z, N, C and V flags.
// - Condition codes 0x10-0x1F are forwarded to the extension logic.
// - The host starts, stops and single-steps the core through registers.
// - Breakpoint and halting flag write both stop the core.
// - Sleep stalls the pipeline and disables on-chip RAM until woken.
// - The auxiliary space holds up to 4G word locations, apart from memory.
// - Data and instruction fetch share one address map by default.
// - Byte order is little-endian unless big-endian is built in and chosen.
// - Byte and half loads sit in low bits, zero or sign filled.
// - Misaligned accesses trap in the privileged implementation, else pass to memory.
// - A byte access touches exactly the addressed byte in either order.
// - Widen operations extend a low byte or half to 32 bits.
// - Bit operations select any one of 32 bits by immediate index.
// - Dual 16-bit operands: bits 31:16 channel 1, bits 15:0 channel 2.
// - 24-bit fractions sit in bits 31:8; the low byte is ignored.
// - Source register 62 means the next word is long immediate data.
module idf_core import idf_pkg::*; #(
  parameter bit BIG_ENDIAN_OPT = 1'b0,
  parameter bit PRIV_IMPL = 1'b1
) (
  // Clock, reset and enable
  input logic CLOCK,
  input logic SYS_RST,
  input logic CLK_EN,
  // AHB-Lite slave
  input logic HSEL,
  input logic [31:0] HADDR,
  input logic [1:0] HTRANS,
  input logic HWRITE,
  input logic [2:0] HSIZE,
  input logic [31:0] HWDATA,
  input logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  // Instruction decode
  input logic INSN_VALID,
  input logic [31:0] INSN_WORD,
  input logic FLAG_Z,
  input logic FLAG_N,
  input logic FLAG_C,
  input logic FLAG_V,
  input logic EXT_COND_TRUE,
  output logic DEC_VALID,
  output logic DEC_IS32,
  output logic [4:0] DEC_GROUP,
  output logic DEC_WB_EXT,
  output logic DEC_USER_EXT,
  output logic [5:0] DEC_SRC_B,
  output logic [5:0] DEC_SRC_C,
  output logic [5:0] DEC_DEST,
  output logic [2:0] DEC_REG_EXT,
  output logic DEC_LIMM,
  output logic DEC_CC_EXT,
  output logic DEC_CC_PASS,
  // Run control
  input logic BRK_EXEC,
  input logic FLAG_HALT_EXEC,
  input logic SLEEP_EXEC,
  input logic IRQ_PENDING,
  output logic CORE_RUN,
  output logic HALTED,
  output logic RAM_EN,
  // Auxiliary access check
  input logic AUX_REQ,
  input logic AUX_WRITE,
  input logic [31:0] AUX_ADDR,
  output logic AUX_ACK,
  output logic AUX_BCR,
  output logic AUX_WR_ERR,
  // Load and store formatting
  input logic LS_VALID,
  input logic [31:0] LS_ADDR,
  input logic [1:0] LS_SIZE,
  input logic LS_SIGNED,
  input logic [31:0] LS_RDATA,
  output logic LS_DONE,
  output logic [31:0] LS_MEM_ADDR,
  output logic [31:0] LS_DATA,
  output logic LS_MISALIGN,
  output logic LS_FAULT,
  // Widen, bit and extended arithmetic operands
  input logic WID_VALID,
  input logic [1:0] WID_OP,
  input logic [31:0] WID_SRC,
  output logic [31:0] WID_RESULT,
  input logic [4:0] BIT_IDX,
  input logic [31:0] BIT_SRC,
  output logic BIT_VALUE,
  output logic [31:0] BIT_MASK,
  input logic [31:0] XA_SRC,
  output logic [15:0] XA_CH1,
  output logic [15:0] XA_CH2,
  output logic [23:0] XA_FRAC24
);
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic reg_is_ext(input logic [5:0] r);
    return (r >= EXT_REG_LO) && (r <= EXT_REG_HI);
  endfunction : reg_is_ext

  // Short forms reach only r0-r3 and r12-r15.
  function automatic logic [5:0] map16(input logic [2:0] r);
    return {2'h0, r[2], r[2], r[1:0]};
  endfunction : map16

  function automatic logic in_bcr(input logic [31:0] a);
    return ((a >= BCR_LO_A) && (a <= BCR_HI_A)) || ((a >= BCR_LO_B) && (a <= BCR_HI_B));
  endfunction : in_bcr

  // ----------------------------------------
  // Instruction decode
  // ----------------------------------------
  wire [4:0] grp = INSN_WORD[GRP_MSB:GRP_LSB];
  wire is32 = grp <= GRP_LAST32;
  wire ext_grp = is32 ? (grp == GRP_EXT32_USER || grp == GRP_EXT32_RSV)
                      : (grp == GRP_EXT16_A || grp == GRP_EXT16_B);
  wire user_ext = grp == GRP_EXT32_USER || grp == GRP_EXT16_A || grp == GRP_EXT16_B;
  wire [5:0] b32 = {INSN_WORD[B_HI_MSB:B_HI_LSB], INSN_WORD[B_LO_MSB:B_LO_LSB]};
  wire [5:0] src_b = is32 ? b32 : map16(INSN_WORD[B_LO_MSB:B_LO_LSB]);
  wire [5:0] src_c = is32 ? INSN_WORD[C_MSB:C_LSB] : map16(INSN_WORD[S16_C_MSB:S16_C_LSB]);
  wire [5:0] dest = is32 ? INSN_WORD[A_MSB:A_LSB] : src_b;
  wire [2:0] reg_ext = {reg_is_ext(dest), reg_is_ext(src_c), reg_is_ext(src_b)};
  wire limm = (src_b == LIMM_REG) || (src_c == LIMM_REG);
  wire cc_pass;
  wire cc_ext;

  idf_cond u_cond (
    .code(INSN_WORD[CC_MSB:CC_LSB]),
    .z(FLAG_Z),
    .n(FLAG_N),
    .c(FLAG_C),
    .v(FLAG_V),
    .ext_true(EXT_COND_TRUE),
    .pass(cc_pass),
    .is_ext(cc_ext)
  );

  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      DEC_VALID <= 1'b0;
      {DEC_IS32, DEC_GROUP, DEC_WB_EXT, DEC_USER_EXT} <= 8'h00;
      {DEC_SRC_B, DEC_SRC_C, DEC_DEST, DEC_REG_EXT} <= 21'h0;
      {DEC_LIMM, DEC_CC_EXT, DEC_CC_PASS} <= 3'h0;
    end else if (CLK_EN) begin
      DEC_VALID <= INSN_VALID;
      if (INSN_VALID) begin
        {DEC_IS32, DEC_GROUP} <= {is32, grp};
        DEC_WB_EXT <= ext_grp;
        DEC_USER_EXT <= user_ext;
        {DEC_SRC_B, DEC_SRC_C, DEC_DEST, DEC_REG_EXT} <= {src_b, src_c, dest, reg_ext};
        DEC_LIMM <= limm;
        // Short forms carry no condition field and always execute.
        DEC_CC_EXT <= is32 && cc_ext;
        DEC_CC_PASS <= !is32 || cc_pass;
      end
    end
  end

  // ----------------------------------------
  // Bus slave
  // ----------------------------------------
  // Writes land in the data phase; a read placed right behind a write to the same
  // register returns the older value, so software reads back after an idle cycle.
  wire bus_take = HSEL && HREADY && HTRANS[1];
  logic wr_pend_r;
  logic [7:0] wofs_r;
  logic cfg_be_r;
  logic [2:0] st_r;
  idf_run_t run_r;
  idf_run_t run_nxt;
  logic [31:0] dec_word_r;
  wire [31:0] ls_fmt;
  wire ls_mis;
  wire wr_dbg = wr_pend_r && wofs_r == OFS_DBG;
  wire cmd_start = wr_dbg && HWDATA[DBG_START];
  wire cmd_stop = wr_dbg && HWDATA[DBG_STOP];
  wire cmd_step = wr_dbg && HWDATA[DBG_STEP];
  wire [2:0] st_clr = (wr_pend_r && wofs_r == OFS_STAT) ? HWDATA[4:2] : 3'h0;
  wire [7:0] rofs = HADDR[7:0];
  wire [31:0] rd_mux = (rofs == OFS_DBG) ? {30'h0, run_r} :
                       (rofs == OFS_STAT) ? {27'h0, st_r, run_r == SLEEP, HALTED} :
                       (rofs == OFS_CFG) ? {31'h0, cfg_be_r} :
                       (rofs == OFS_DEC) ? dec_word_r : 32'h0;

  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      wr_pend_r <= 1'b0;
      wofs_r <= OFS_DBG;
      HRDATA <= 32'h0;
      HREADYOUT <= 1'b1;
      HRESP <= 1'b0;
    end else if (CLK_EN) begin
      wr_pend_r <= bus_take && HWRITE;
      wofs_r <= HADDR[7:0];
      HRDATA <= (bus_take && !HWRITE) ? rd_mux : 32'h0;
    end
  end

  // Big-endian can only be chosen when the build allows it.
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      cfg_be_r <= 1'b0;
    end else if (CLK_EN && wr_pend_r && wofs_r == OFS_CFG) begin
      cfg_be_r <= BIG_ENDIAN_OPT & HWDATA[CFG_BE];
    end
  end

  // ----------------------------------------
  // Run control
  // ----------------------------------------
  always_comb begin
    run_nxt = run_r;
    unique case (run_r)
      RUN: if (SLEEP_EXEC) run_nxt = SLEEP;
      HALT: if (cmd_step) run_nxt = STEP; else if (cmd_start) run_nxt = RUN;
      STEP: if (INSN_VALID) run_nxt = HALT;
      SLEEP: if (IRQ_PENDING || cmd_start) run_nxt = RUN;
    endcase
    if (cmd_stop || BRK_EXEC || FLAG_HALT_EXEC) begin
      run_nxt = HALT;
    end
  end

  // The pipeline keeps its PC through sleep, so it resumes after the sleep instruction.
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      run_r <= RUN;
      CORE_RUN <= 1'b1;
      HALTED <= 1'b0;
      RAM_EN <= 1'b1;
    end else if (CLK_EN) begin
      run_r <= run_nxt;
      CORE_RUN <= run_nxt == RUN || run_nxt == STEP;
      HALTED <= run_nxt == HALT;
      RAM_EN <= run_nxt != SLEEP;
    end
  end

  // Sticky flags: a new event wins over a clear in the same cycle.
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      st_r <= 3'h0;
      dec_word_r <= 32'h0;
    end else if (CLK_EN) begin
      st_r <= (st_r & ~st_clr) | {LS_VALID && ls_mis, FLAG_HALT_EXEC, BRK_EXEC};
      if (INSN_VALID) begin
        dec_word_r <= {23'h0, limm, user_ext, ext_grp, is32, grp};
      end
    end
  end

  // ----------------------------------------
  // Auxiliary access check
  // ----------------------------------------
  // Only whole-word transfers exist, so the address is a word index.
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      {AUX_ACK, AUX_BCR, AUX_WR_ERR} <= 3'h0;
    end else if (CLK_EN) begin
      AUX_ACK <= AUX_REQ;
      AUX_BCR <= AUX_REQ && in_bcr(AUX_ADDR);
      AUX_WR_ERR <= AUX_REQ && AUX_WRITE && in_bcr(AUX_ADDR);
    end
  end

  // ----------------------------------------
  // Load, widen, bit and operand formats
  // ----------------------------------------
  idf_ldfmt u_ldfmt (
    .addr(LS_ADDR[1:0]),
    .size(LS_SIZE),
    .sgn(LS_SIGNED),
    .big(cfg_be_r),
    .rdata(LS_RDATA),
    .data(ls_fmt),
    .misaligned(ls_mis)
  );

  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      {LS_DONE, LS_MISALIGN, LS_FAULT} <= 3'h0;
      {LS_MEM_ADDR, LS_DATA} <= 64'h0;
    end else if (CLK_EN) begin
      LS_DONE <= LS_VALID;
      LS_MEM_ADDR <= LS_ADDR;
      LS_DATA <= ls_fmt;
      LS_MISALIGN <= LS_VALID && ls_mis;
      LS_FAULT <= PRIV_IMPL && LS_VALID && ls_mis;
    end
  end

  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      WID_RESULT <= 32'h0;
      {BIT_VALUE, BIT_MASK} <= 33'h0;
      {XA_CH1, XA_CH2, XA_FRAC24} <= 56'h0;
    end else if (CLK_EN) begin
      if (WID_VALID) begin
        WID_RESULT <= idf_widen(WID_SRC, WID_OP[1], WID_OP[0]);
      end
      BIT_VALUE <= BIT_SRC[BIT_IDX];
      BIT_MASK <= 32'h1 << BIT_IDX;
      {XA_CH1, XA_CH2} <= XA_SRC;
      XA_FRAC24 <= XA_SRC[31:8];
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (SYS_RST);

  sequence sleep_entry;
    CLK_EN && run_r == RUN && SLEEP_EXEC && !cmd_stop && !BRK_EXEC && !FLAG_HALT_EXEC;
  endsequence
  sequence wake_up;
    CLK_EN && run_r == SLEEP && IRQ_PENDING && !cmd_stop && !BRK_EXEC && !FLAG_HALT_EXEC;
  endsequence

  limm_fetch_a: assert property (CLK_EN && INSN_VALID && src_b == LIMM_REG |=> DEC_LIMM)
    else $error("long immediate not flagged");
  ext_reg_a: assert property (CLK_EN && INSN_VALID |=> DEC_REG_EXT[0] == ($past(src_b) >= 6'h20 && $past(src_b) <= 6'h3B))
    else $error("extension register range wrong");
  group_len_a: assert property (CLK_EN && INSN_VALID |=> DEC_IS32 == ($past(INSN_WORD[31:27]) < 5'h08))
    else $error("group length wrong");
  bcr_write_a: assert property (CLK_EN && AUX_REQ && AUX_WRITE && AUX_ADDR[31:5] == 27'h3 |=> AUX_WR_ERR)
    else $error("build config write not refused");
  cc_forward_a: assert property (CLK_EN && INSN_VALID && is32 && INSN_WORD[4] |=> DEC_CC_EXT && DEC_CC_PASS == $past(EXT_COND_TRUE))
    else $error("extension condition not forwarded");
  step_once_a: assert property (CLK_EN && run_r == STEP && INSN_VALID |=> HALTED && !CORE_RUN)
    else $error("single step did not halt");
  brk_halt_a: assert property (CLK_EN && BRK_EXEC |=> HALTED && st_r[0])
    else $error("breakpoint did not halt");
  sleep_ram_a: assert property (sleep_entry |=> !RAM_EN && !CORE_RUN && !HALTED)
    else $error("sleep did not stall");
  sleep_wake_a: assert property (wake_up |=> CORE_RUN && RAM_EN)
    else $error("sleep did not end on wake");
  misalign_a: assert property (CLK_EN && LS_VALID && LS_SIZE == 2'h2 && LS_ADDR[0] |=> LS_FAULT == PRIV_IMPL && LS_MISALIGN)
    else $error("misaligned half not flagged");
  byte_load_a: assert property (CLK_EN && LS_VALID && LS_SIZE == 2'h1 && !LS_SIGNED |=> LS_DATA[31:8] == 24'h0 && !LS_FAULT)
    else $error("byte load not zero filled");
endmodule : idf_core

// *** verification/idf_mem_model.sv ***
// Data memory model that answers word reads for the load formatting path.
module idf_mem_model import idf_pkg::*; (
  // Access
  input wire logic [31:0] addr,
  output logic [31:0] rdata
);
  // ----------------------------------------
  // Unified memory image
  // ----------------------------------------
  // Every byte differs from its neighbours, so a lane mix-up cannot hide.
  function automatic logic [7:0] pat(input logic [31:0] a);
    return a[7:0] ^ 8'hA5;
  endfunction : pat

  logic [31:0] wa;
  assign wa = {addr[31:2], 2'h0};
  assign rdata = {pat(wa + 32'h3), pat(wa + 32'h2), pat(wa + 32'h1), pat(wa)};
endmodule : idf_mem_model

// *** verification/idf_core_tb.sv ***
// Self-checking bench for the decode, run control and data format block.
module idf_core_tb import idf_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic clock = 1'b0;
  logic sys_rst, clk_en, hwrite, hready, hresp, iv, ect, aq, aw, lv, lsg, wv;
  logic [1:0] htrans, lsz, wop;
  logic [31:0] haddr, hwdata, hrdata, iw, aa, la, lrd, ws, bs, xs;
  logic [3:0] fl;
  logic [4:0] ev, bi, dgrp;
  logic dv, d32, dwb, dux, dlimm, dcce, dccp, run, halted, ram_en, ack, build_config_regs, werr, ldone, lmis, lfault, bval;
  logic [5:0] db, dc, dd;
  logic [2:0] dre;
  logic [31:0] lmaddr, ldata, wres, bmask;
  logic [15:0] ch1, ch2;
  logic [23:0] f24;
  int fails = 0;
  int compares = 0;
  logic [5:0] corner [5] = '{6'h20, 6'h3B, 6'h3C, 6'h3E, 6'h1F};
  logic [31:0] atab [8] = '{32'h5F, 32'h60, 32'h7F, 32'h80, 32'hBF, 32'hC0, 32'hFF, 32'h0001_0060};

  always #2 clock = ~clock;

  idf_core DUT (
    .CLOCK(clock), .SYS_RST(sys_rst), .CLK_EN(clk_en),
    .HSEL(1'b1), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(HSIZE_WORD), .HWDATA(hwdata),
    .HREADY(hready), .HRDATA(hrdata), .HREADYOUT(hready), .HRESP(hresp),
    .INSN_VALID(iv | ev[4]), .INSN_WORD(iw), .FLAG_Z(fl[3]), .FLAG_N(fl[2]), .FLAG_C(fl[1]), .FLAG_V(fl[0]),
    .EXT_COND_TRUE(ect), .DEC_VALID(dv), .DEC_IS32(d32), .DEC_GROUP(dgrp), .DEC_WB_EXT(dwb),
    .DEC_USER_EXT(dux), .DEC_SRC_B(db), .DEC_SRC_C(dc), .DEC_DEST(dd), .DEC_REG_EXT(dre),
    .DEC_LIMM(dlimm), .DEC_CC_EXT(dcce), .DEC_CC_PASS(dccp),
    .BRK_EXEC(ev[0]), .FLAG_HALT_EXEC(ev[1]), .SLEEP_EXEC(ev[2]), .IRQ_PENDING(ev[3]),
    .CORE_RUN(run), .HALTED(halted), .RAM_EN(ram_en),
    .AUX_REQ(aq), .AUX_WRITE(aw), .AUX_ADDR(aa), .AUX_ACK(ack), .AUX_BCR(build_config_regs), .AUX_WR_ERR(werr),
    .LS_VALID(lv), .LS_ADDR(la), .LS_SIZE(lsz), .LS_SIGNED(lsg), .LS_RDATA(lrd), .LS_DONE(ldone),
    .LS_MEM_ADDR(lmaddr), .LS_DATA(ldata), .LS_MISALIGN(lmis), .LS_FAULT(lfault),
    .WID_VALID(wv), .WID_OP(wop), .WID_SRC(ws), .WID_RESULT(wres),
    .BIT_IDX(bi), .BIT_SRC(bs), .BIT_VALUE(bval), .BIT_MASK(bmask),
    .XA_SRC(xs), .XA_CH1(ch1), .XA_CH2(ch2), .XA_FRAC24(f24)
  );

  idf_mem_model MEM (.addr(la), .rdata(lrd));

  // ----------------------------------------
  // Expectations and checks
  // ----------------------------------------
  function automatic logic [7:0] pat(input logic [31:0] a);
    return a[7:0] ^ 8'hA5;
  endfunction : pat

  function automatic logic [31:0] wid(input logic [31:0] v, input logic h, input logic s);
    return h ? {{16{s & v[15]}}, v[15:0]} : {{24{s & v[7]}}, v[7:0]};
  endfunction : wid

  // Short forms name r0-r3 directly and r12-r15 through codes 4 to 7.
  function automatic logic [5:0] m16(input logic [2:0] r);
    return r[2] ? 6'(r) + 6'h08 : 6'(r);
  endfunction : m16

  function automatic logic inx(input logic [5:0] r);
    return r >= 6'h20 && r <= 6'h3B;
  endfunction : inx

  function automatic logic cc(input logic [4:0] k);
    logic z, n, c, v;
    logic [15:0] t;
    {z, n, c, v} = fl;
    t = {!n && !z, c || z, !c && !z, z || (n != v), n != v, n == v, !z && (n == v), !v, v, !c, c, !n, n, !z, z, 1'b1};
    return k[4] ? ect : t[k[3:0]];
  endfunction : cc

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic wrap_up();
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : wrap_up

  // A master that waits on hready, so a slower slave would still be read correctly.
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clock);
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= wr;
    do @(posedge clock); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clock); while (hready !== 1'b1);
    rd = hrdata;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    chk(r, e);
  endtask : rdc

  task automatic pulse(input logic [4:0] m);
    @(posedge clock);
    ev <= m;
    @(posedge clock);
    ev <= 5'h0;
    @(posedge clock);
    #1;
  endtask : pulse

  task automatic check_all();
    logic [4:0] g;
    logic [5:0] b;
    logic x, y;
    logic [31:0] v;
    g = iw[31:27];
    b = {iw[14:12], iw[26:24]};
    chk(dv, 1'b1);
    chk(dgrp, g);
    chk(d32, g <= GRP_LAST32);
    chk(dwb, g inside {5'h05, 5'h06, 5'h09, 5'h0A});
    chk(dux, g inside {5'h05, 5'h09, 5'h0A});
    if (g <= GRP_LAST32) begin
      chk({db, dc, dd}, {b, iw[11:0]});
      chk(dre, {inx(iw[5:0]), inx(iw[11:6]), inx(b)});
      chk(dlimm, b == 6'h3E || iw[11:6] == 6'h3E);
      chk({dcce, dccp}, {iw[4], cc(iw[4:0])});
    end else begin
      chk(dccp, 1'b1);
      chk({db, dc, dd}, {m16(iw[26:24]), m16(iw[23:21]), m16(iw[26:24])});
    end
    x = lsz == SZ_LONG ? la[1:0] != 2'h0 : (lsz == SZ_HALF ? la[0] : 1'b0);
    v = {pat(la + 32'h3), pat(la + 32'h2), pat(la + 32'h1), pat(la)};
    chk({ldone, lmis, lfault}, {1'b1, x, x});
    chk(lmaddr, la);
    if (!x)
      chk(ldata, lsz == SZ_LONG ? v : wid(v, lsz == SZ_HALF, lsg));
    y = (aa >= 32'h60 && aa <= 32'h7F) || (aa >= 32'hC0 && aa <= 32'hFF);
    chk({ack, build_config_regs, werr}, {1'b1, y, aw & y});
    chk(wres, wid(ws, wop[1], wop[0]));
    chk(bval, bs[bi]);
    chk(bmask, 32'h1 << bi);
    chk({ch1, ch2}, xs);
    chk(f24, xs[31:8]);
  endtask : check_all

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    #50000;
    fails++;
    $display("watchdog expired");
    wrap_up();
  end

  initial begin
    logic [31:0] w;
    logic [5:0] r;
    sys_rst = 1'b1;
    clk_en = 1'b1;
    {iv, aq, aw, lv, lsg, wv, ect, hwrite} = 8'h0;
    {iw, aa, la, ws, bs, xs, haddr, hwdata} = 256'h0;
    {fl, lsz, wop, bi, ev, htrans} = 20'h0;
    void'($urandom(92));
    repeat (12) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
    #1;
    chk({run, halted, ram_en, hready, hresp}, 5'h16);
    rdc(OFS_DBG, 32'h0);
    rdc(OFS_CFG, 32'h0);
    wr(OFS_CFG, 32'h1);
    rdc(OFS_CFG, 32'h0);
    rdc(8'h10, 32'h0);
    $display("test registers done");
    for (int i = 0; i < 320; i++) begin
      @(posedge clock);
      w = $urandom;
      w[31:27] = i[4:0];
      if (i % 3 == 0) begin
        r = corner[i % 5];
        w[14:12] = r[5:3];
        w[26:24] = r[2:0];
        w[11:6] = corner[(i + 2) % 5];
      end
      {iv, aq, lv, wv} <= 4'hF;
      iw <= w;
      fl <= 4'($urandom);
      ect <= 1'($urandom);
      aw <= 1'($urandom);
      aa <= (i % 2 == 1) ? $urandom : atab[(i / 2) % 8];
      la <= $urandom & 32'hFF;
      lsz <= 2'($urandom % 3);
      lsg <= 1'($urandom);
      wop <= 2'($urandom);
      ws <= $urandom;
      bi <= 5'($urandom);
      bs <= $urandom;
      xs <= $urandom;
      @(posedge clock);
      #1;
      check_all();
    end
    @(posedge clock);
    {iv, aq, lv, wv} <= 4'h0;
    rdc(OFS_DEC, 32'h1F);
    rdc(OFS_STAT, 32'h10);
    wr(OFS_STAT, 32'h10);
    $display("test datapath done");
    wr(OFS_DBG, 32'h2);
    rdc(OFS_DBG, 32'h1);
    chk({halted, run}, 2'h2);
    wr(OFS_DBG, 32'h4);
    rdc(OFS_DBG, 32'h2);
    pulse(5'h10);
    rdc(OFS_DBG, 32'h1);
    wr(OFS_DBG, 32'h1);
    rdc(OFS_DBG, 32'h0);
    pulse(5'h01);
    rdc(OFS_STAT, 32'h5);
    wr(OFS_DBG, 32'h1);
    wr(OFS_STAT, 32'h4);
    pulse(5'h02);
    rdc(OFS_STAT, 32'h9);
    wr(OFS_DBG, 32'h1);
    wr(OFS_STAT, 32'h8);
    rdc(OFS_STAT, 32'h0);
    $display("test run control done");
    pulse(5'h04);
    chk({run, ram_en}, 2'h0);
    rdc(OFS_STAT, 32'h2);
    pulse(5'h08);
    chk({run, ram_en}, 2'h3);
    pulse(5'h04);
    rdc(OFS_DBG, 32'h3);
    wr(OFS_DBG, 32'h1);
    rdc(OFS_DBG, 32'h0);
    chk({run, ram_en}, 2'h3);
    $display("test sleep done");
    // A breakpoint arriving while the enable is low must leave every flop untouched.
    @(posedge clock);
    clk_en <= 1'b0;
    pulse(5'h01);
    chk({halted, run}, 2'h1);
    @(posedge clock);
    clk_en <= 1'b1;
    rdc(OFS_STAT, 32'h0);
    $display("test clock enable done");
    wrap_up();
  end
endmodule : idf_core_tb
